// ===== pci_backend_flow_control.sv
// pci target burst flow control towards a backend memory or fifo
// assumes the target controller drives the burst levels and start pulse,
// and that read and write bursts never overlap
//
// How it works
// - read prefetch holds at most five words
// - fetching stops at five, resumes at four
// - pipelined mode captures one edge after handshake
// - read ready held while buffer not full
// - captured word reaches pci two cycles later
// - address steps one word after each write
// - write ready from backend raises target ready
// - strobes follow target ready and initiator ready
// - at most two writes after ready withdrawn
// - read word moves only when both strobes active
// - direct mode captures on the handshake edge
// - one strobe per lane with address, data
`timescale 1ns/10ps
`default_nettype none

module pci_backend_flow_control
  import flow_ctl_pkg::*;
#(
  parameter int EXTRA_LAT = EXTRA_LAT_STD
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // burst control from the target controller
  input  wire logic              rd_burst,
  input  wire logic              wr_burst,
  input  wire logic              burst_start,
  input  wire logic [ADDR_W-1:0] start_addr,
  input  wire logic              rd_sync,
  // pci data phase
  input  wire logic              pci_irdy_n,
  input  wire logic [DATA_W-1:0] pci_ad_in,
  input  wire logic [LANES-1:0]  pci_cbe_n,
  output logic                   pci_trdy_n,
  output logic      [DATA_W-1:0] pci_ad_out,
  // backend read handshake
  output logic                   rd_ready,
  input  wire logic              rd_valid,
  input  wire logic [DATA_W-1:0] rd_data,
  // backend write handshake
  input  wire logic              write_accept_ready,
  output logic      [LANES-1:0]  write_byte_strobes,
  output logic      [DATA_W-1:0] wr_data,
  // backend address
  output logic      [ADDR_W-1:0] mem_addr
);

  if (EXTRA_LAT != EXTRA_LAT_STD && EXTRA_LAT != EXTRA_LAT_SLOW) begin : g_bad_lat
    $error("EXTRA_LAT must be 0 or 1");
  end
  if (RD_BUF_WORDS + EXTRA_LAT > FIFO_DEPTH) begin : g_bad_depth
    $error("read buffer limit exceeds fifo depth");
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic              pci_trdy_n_q;
  logic [DATA_W-1:0] pci_ad_out_q;
  logic              rd_ready_q;
  logic              take_q;
  logic [OCC_W-1:0]  occ_q;
  wr_beat_s          wr_beat_q;
  logic [ADDR_W-1:0] mem_addr_q;

  assign pci_trdy_n         = pci_trdy_n_q;
  assign pci_ad_out         = pci_ad_out_q;
  assign rd_ready           = rd_ready_q;
  assign write_byte_strobes = wr_beat_q.strobes;
  assign wr_data            = wr_beat_q.data;
  assign mem_addr           = mem_addr_q;

  wire irdy = !pci_irdy_n;
  wire trdy = !pci_trdy_n_q;

  // a data phase completes when target and initiator are ready together
  function automatic logic beat_done(input logic t_ready, input logic i_ready);
    return t_ready && i_ready;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // backend read capture

  // a word moves only on ready and valid together
  wire take = rd_burst && rd_ready_q && rd_valid;

  cap_s cap_in;
  cap_s cap;

  // pipelined backends present data one edge after the strobes
  assign cap_in.valid = rd_burst && (rd_sync ? take_q : take);
  assign cap_in.data  = rd_data;

  // slow families get one more stage before the buffer
  stage_delay #(
    .WIDTH ($bits(cap_s)),
    .DEPTH (EXTRA_LAT)
  ) u_lat (
    .clk   (ref_clk),
    .reset (reset),
    .din   (cap_in),
    .dout  (cap)
  );

  ////////////////////////////////////////////////////////////////////////////
  // prefetch buffer and pci delivery

  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;

  // a new word may be put on the bus when the slot is empty or just taken
  wire load_slot = rd_burst && (!trdy || irdy);
  wire pop       = load_slot && fifo_out_valid;
  wire delivered = rd_burst && beat_done(trdy, irdy);

  // leftovers are dropped at burst end; recovery lives elsewhere
  word_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_buf (
    .clk       (ref_clk),
    .reset     (reset),
    .flush     (!rd_burst),
    .in_valid  (cap.valid && rd_burst),
    .in_ready  (fifo_in_ready),
    .in_data   (cap.data),
    .out_valid (fifo_out_valid),
    .out_ready (load_slot),
    .out_data  (fifo_out_data)
  );

  // in-flight words count too, so the limit holds across the pipeline
  wire [OCC_W-1:0] occ_d = rd_burst
                         ? occ_q + OCC_W'(take) - OCC_W'(delivered)
                         : '0;

  // ready never waits on the pci master, only on buffer room
  wire rd_ready_d = rd_burst && (occ_d <= RD_RESUME_WORDS) && fifo_in_ready;

  ////////////////////////////////////////////////////////////////////////////
  // write pacing

  wire wr_done = wr_burst && beat_done(trdy, irdy);

  // target ready is held until the master takes the beat
  wire wr_trdy_d = wr_burst && (write_accept_ready || (trdy && !irdy));
  wire rd_trdy_d = pop || (rd_burst && trdy && !irdy);
  wire trdy_d    = rd_burst ? rd_trdy_d : wr_trdy_d;

  wr_beat_s wr_beat_d;
  assign wr_beat_d.strobes = wr_done ? ~pci_cbe_n : NO_LANES;
  assign wr_beat_d.data    = wr_done ? pci_ad_in : wr_beat_q.data;

  wire wrote = (wr_beat_q.strobes != NO_LANES);

  wire [ADDR_W-1:0] mem_addr_d = burst_start     ? start_addr
                               : (take || wrote) ? mem_addr_q + WORD_STEP
                               : mem_addr_q;

  ////////////////////////////////////////////////////////////////////////////
  // state

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pci_trdy_n_q <= 1'b1;
      pci_ad_out_q <= '0;
      rd_ready_q   <= 1'b0;
      take_q       <= 1'b0;
      occ_q        <= '0;
    end else begin
      pci_trdy_n_q <= !trdy_d;
      pci_ad_out_q <= pop ? fifo_out_data : pci_ad_out_q;
      rd_ready_q   <= rd_ready_d;
      take_q       <= take;
      occ_q        <= occ_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_beat_q  <= '0;
      mem_addr_q <= '0;
    end else begin
      wr_beat_q  <= wr_beat_d;
      mem_addr_q <= mem_addr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // writes seen since write ready was last high
  logic [1:0] overrun_q;
  always_ff @(posedge ref_clk) begin
    if (reset || write_accept_ready || !wr_burst) begin
      overrun_q <= '0;
    end else if (wrote && overrun_q != 2'h3) begin
      overrun_q <= overrun_q + 2'h1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_buffer_limit: assert property (occ_q <= RD_BUF_WORDS)
    else $error("read buffer holds more than five words");

  a_stop_when_full: assert property (
    (occ_q == RD_BUF_WORDS) |-> !rd_ready_q ##1 (!rd_ready_q || occ_q <= RD_RESUME_WORDS))
    else $error("read ready raised with a full buffer");

  a_ready_while_room: assert property (
    ($past(rd_burst) && rd_burst && occ_q <= RD_RESUME_WORDS && $past(fifo_in_ready))
      |-> rd_ready_q)
    else $error("read ready dropped while buffer had room");

  a_pipelined_capture: assert property (
    (rd_burst && rd_sync && take) ##1 (rd_burst && rd_sync) |-> cap_in.valid)
    else $error("pipelined capture not one edge after handshake");

  a_direct_capture: assert property (
    (rd_burst && !rd_sync) |-> (cap_in.valid == take))
    else $error("direct capture not on the handshake edge");

  a_read_handshake: assert property (
    cap_in.valid |-> (rd_sync ? $past(rd_ready_q && rd_valid) : (rd_ready_q && rd_valid)))
    else $error("read word taken without both strobes");

  a_pci_latency: assert property (
    (cap.valid && !fifo_out_valid && !trdy && rd_burst) ##1 rd_burst
      |=> (!pci_trdy_n_q && pci_ad_out_q == $past(cap.data, 2)))
    else $error("captured word not on pci two cycles later");

  a_trdy_on_ready: assert property (
    (wr_burst && !rd_burst && write_accept_ready) |=> !pci_trdy_n_q)
    else $error("target ready missing after write ready");

  a_strobe_after_trdy: assert property (
    (wr_burst && !rd_burst && trdy && irdy)
      |=> (write_byte_strobes == ~$past(pci_cbe_n) && wr_data == $past(pci_ad_in)))
    else $error("byte strobes or data wrong after target ready");

  a_strobe_only_on_beat: assert property (
    (wrote) |-> $past(wr_done))
    else $error("byte strobes without a completed pci beat");

  a_addr_advance: assert property (
    (wrote && !burst_start) |=> (mem_addr_q == $past(mem_addr_q) + WORD_STEP))
    else $error("backend address did not step after a write");

  a_overrun_bound: assert property (overrun_q <= WR_OVERRUN_MAX)
    else $error("more than two writes after write ready removed");

  a_trdy_outside_burst: assert property (
    (!rd_burst && !wr_burst) |=> pci_trdy_n_q)
    else $error("target ready asserted outside a burst");

  a_ready_at_start: assert property (
    $rose(rd_burst) |=> rd_ready_q)
    else $error("read ready not raised at burst start");

  a_take_below_limit: assert property (
    take |-> (occ_q < RD_BUF_WORDS))
    else $error("backend word taken with a full buffer");

  a_ready_drops_full: assert property (
    (take && !delivered && occ_q == RD_RESUME_WORDS) |=> !rd_ready_q)
    else $error("read ready kept after the fifth word");

  a_addr_load: assert property (
    burst_start |=> (mem_addr_q == $past(start_addr)))
    else $error("backend address not loaded at burst start");

  a_strobes_in_burst: assert property (
    !$past(wr_burst) |-> !wrote)
    else $error("byte strobes outside a write burst");

  c_buffer_full:    cover property (rd_burst && occ_q == RD_BUF_WORDS);
  c_resume:         cover property ((occ_q == RD_BUF_WORDS) ##1 rd_ready_q);
  c_pipelined_read: cover property (rd_sync && cap_in.valid);
  c_write_overrun:  cover property (overrun_q == WR_OVERRUN_MAX);
  c_write_pulse:    cover property (write_accept_ready ##1 !write_accept_ready ##1 wrote);

endmodule

`default_nettype wire

// ===== flow_ctl_pkg.sv
// constants and carriers shared by the backend flow control block
// assumes one clock domain; all pci and backend pins synchronous to it
`default_nettype none

package flow_ctl_pkg;

  // datapath shape
  localparam int DATA_W     = 32;
  localparam int LANES      = 4;
  localparam int ADDR_W     = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int OCC_W      = 5;

  // read prefetch limits, in words
  localparam logic [OCC_W-1:0] RD_BUF_WORDS    = 5'h05;
  localparam logic [OCC_W-1:0] RD_RESUME_WORDS = 5'h04;

  // backend address step per word, in bytes
  localparam logic [ADDR_W-1:0] WORD_STEP = 16'h0004;

  // extra backend-to-pci stages; slow families need one more
  localparam int EXTRA_LAT_STD  = 0;
  localparam int EXTRA_LAT_SLOW = 1;
  localparam int PCI_LAT_STD    = 2;

  // writes allowed after a continuous ready is withdrawn
  localparam logic [1:0] WR_OVERRUN_MAX = 2'h2;

  localparam logic [LANES-1:0] NO_LANES = 4'h0;

  // one backend read word on its way to the buffer
  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } cap_s;

  // one backend write beat
  typedef struct packed {
    logic [LANES-1:0]  strobes;
    logic [DATA_W-1:0] data;
  } wr_beat_s;

endpackage

`default_nettype wire

// ===== word_fifo.sv
// synchronous fifo with valid/ready on both sides and a flush
// assumes flush and reset are synchronous to clk
`timescale 1ns/10ps
`default_nettype none

module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             flush,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("word_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_ptr_q;
  logic [PW:0]      rd_ptr_q;

  wire full  = (wr_ptr_q[PW] != rd_ptr_q[PW]) && (wr_ptr_q[PW-1:0] == rd_ptr_q[PW-1:0]);
  wire empty = (wr_ptr_q == rd_ptr_q);
  wire push  = in_valid && !full;
  wire pop   = out_ready && !empty;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_q[PW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_q + (PW+1)'(push);
      rd_ptr_q <= rd_ptr_q + (PW+1)'(pop);
    end
  end

endmodule

`default_nettype wire

// ===== stage_delay.sv
// fixed register delay line; depth zero is a straight wire
// assumes reset synchronous to clk
`timescale 1ns/10ps
`default_nettype none

module stage_delay #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  if (DEPTH < 0 || DEPTH > 4) begin : g_bad_depth
    $error("stage_delay depth must lie in 0..4");
  end

  if (DEPTH == 0) begin : g_wire
    assign dout = din;
  end else begin : g_regs
    logic [WIDTH-1:0] stage_q [DEPTH];
    for (genvar i = 0; i < DEPTH; i++) begin : g_stage
      always_ff @(posedge clk) begin
        if (reset) begin
          stage_q[i] <= '0;
        end else begin
          stage_q[i] <= (i == 0) ? din : stage_q[(i == 0) ? 0 : i-1];
        end
      end
    end
    assign dout = stage_q[DEPTH-1];
  end

endmodule

`default_nettype wire

// ===== backend_model.sv
// backend memory model answering the flow control block
// assumes one clock; the word at an address is {~addr, addr}
`timescale 1ns/10ps
`default_nettype none

module backend_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // modes set by the bench
  input  wire logic        slow,
  input  wire logic        wr_pulse,
  input  wire logic        rd_sync,
  // block side
  input  wire logic        rd_burst,
  input  wire logic        wr_burst,
  input  wire logic        rd_ready,
  input  wire logic [15:0] mem_addr,
  input  wire logic [3:0]  write_byte_strobes,
  output logic             rd_valid,
  output logic      [31:0] rd_data,
  output logic             write_accept_ready
);
  logic [1:0]  ph_q;
  logic        hs_q;
  logic        wait_q;
  logic [31:0] pipe_q;
  wire  logic [31:0] word = {~mem_addr, mem_addr};

  // slow backend offers a word every third cycle
  assign rd_valid = rd_burst && (!slow || ph_q == 2'h0);
  // idle data shows the inverse, so a stale word never passes
  assign rd_data = rd_sync ? (hs_q ? pipe_q : ~pipe_q) : (rd_valid ? word : ~word);

  always_ff @(posedge ref_clk) begin
    // an offered word stays offered until the block is ready for it
    ph_q   <= reset ? 2'h0 : (rd_valid && !rd_ready) ? ph_q : (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
    hs_q   <= !reset && rd_burst && rd_ready && rd_valid;
    pipe_q <= word;
    if (reset || !wr_burst) begin
      write_accept_ready <= 1'b0;
      wait_q             <= 1'b0;
    end else if (!wr_pulse) begin
      write_accept_ready <= 1'b1;
    end else if (wait_q) begin
      write_accept_ready <= 1'b0;
      wait_q             <= write_byte_strobes == 4'h0;
    end else begin
      write_accept_ready <= 1'b1;
      wait_q             <= 1'b1;
    end
  end
endmodule

`default_nettype wire

// ===== pci_backend_flow_control_tb.sv
// self-checking bench for the backend flow control block
// assumes backend_model on the far side; one 25 MHz clock
`timescale 1ns/10ps
`default_nettype none

module pci_backend_flow_control_tb;
  import flow_ctl_pkg::*;
  logic ref_clk, reset, rd_burst, wr_burst, burst_start, rd_sync, slow, wr_pulse;
  logic pci_irdy_n, pci_trdy_n, rd_ready, rd_valid, write_accept_ready, lat_chk;
  logic [ADDR_W-1:0] start_addr, mem_addr;
  logic [DATA_W-1:0] pci_ad_in, pci_ad_out, rd_data, wr_data;
  logic [LANES-1:0]  pci_cbe_n, write_byte_strobes;
  logic [51:0]       exp_q[$];
  logic              rd_prev_q, hs_q;
  logic [1:0]        sh_q;
  int                occ, n_mismatch, cmp_count;
  integer            seed = 32'hf6d8a1a7;

  pci_backend_flow_control u_pci_backend_flow_control (.ref_clk(ref_clk), .reset(reset),
    .rd_burst(rd_burst), .wr_burst(wr_burst), .burst_start(burst_start),
    .start_addr(start_addr), .rd_sync(rd_sync), .pci_irdy_n(pci_irdy_n),
    .pci_ad_in(pci_ad_in), .pci_cbe_n(pci_cbe_n), .pci_trdy_n(pci_trdy_n),
    .pci_ad_out(pci_ad_out), .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .write_accept_ready(write_accept_ready), .write_byte_strobes(write_byte_strobes),
    .wr_data(wr_data), .mem_addr(mem_addr));
  backend_model u_backend_model (.ref_clk(ref_clk), .reset(reset), .slow(slow),
    .wr_pulse(wr_pulse), .rd_sync(rd_sync), .rd_burst(rd_burst), .wr_burst(wr_burst),
    .rd_ready(rd_ready), .mem_addr(mem_addr), .write_byte_strobes(write_byte_strobes),
    .rd_valid(rd_valid), .rd_data(rd_data), .write_accept_ready(write_accept_ready));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [51:0] seen, input logic [51:0] expd);
    cmp_count++;
    if (seen !== expd) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask

  function automatic logic [51:0] pop_exp();
    return exp_q.size() ? exp_q.pop_front() : 'x;
  endfunction

  task automatic wrap_up();
    chk(52'(exp_q.size()), 52'h0);
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic timed_out();
    n_mismatch++;
    wrap_up();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watcher: results are taken off the queue in order
  always @(posedge ref_clk) begin
    if (!reset) begin
      if (rd_burst && rd_prev_q) chk(52'(rd_ready), 52'(occ <= 4));
      if (lat_chk && rd_burst && !pci_irdy_n) chk(52'(!pci_trdy_n), 52'(sh_q[1]));
      if (rd_burst && !pci_trdy_n && !pci_irdy_n) chk(52'(pci_ad_out), pop_exp());
      if (write_byte_strobes !== NO_LANES)
        chk({write_byte_strobes, wr_data, mem_addr}, pop_exp());
    end
    hs_q      <= rd_burst && rd_ready && rd_valid;
    sh_q      <= {sh_q[0], rd_sync ? hs_q : rd_burst && rd_ready && rd_valid};
    rd_prev_q <= rd_burst && !reset;
    occ       <= rd_burst ? occ + (rd_ready && rd_valid) - (!pci_trdy_n && !pci_irdy_n) : 0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // drivers
  task automatic rd_run(input logic sy, input logic sl, input int n);
    int got;
    logic [15:0] sa;
    sa = 16'($random(seed)) & 16'h7ffc;
    lat_chk = sl;
    rd_sync     <= sy;
    slow        <= sl;
    burst_start <= 1'b1;
    start_addr  <= sa;
    rd_burst    <= 1'b1;
    for (int k = 0; k < n; k++) exp_q.push_back(52'({~(sa + 16'(4 * k)), sa + 16'(4 * k)}));
    @(posedge ref_clk);
    burst_start <= 1'b0;
    got = 0;
    for (int t = 0; t < 400 && got < n; t++) begin
      // with a slow backend the master is always ready; otherwise a random master leaves the buffer to fill up
      pci_irdy_n <= sl ? 1'b0 : (($random(seed) & 3) != 0);
      @(posedge ref_clk);
      if (pci_trdy_n === 1'b0 && !pci_irdy_n) got++;
    end
    if (got < n) timed_out();
    pci_irdy_n <= 1'b1;
    rd_burst   <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic wr_run(input int n, input int pace);
    logic [31:0] d;
    logic [3:0]  be;
    logic [15:0] sa;
    bit          done;
    sa = 16'($random(seed)) & 16'h7ffc;
    burst_start <= 1'b1;
    start_addr  <= sa;
    wr_burst    <= 1'b1;
    @(posedge ref_clk);
    burst_start <= 1'b0;
    for (int k = 0; k < n; k++) begin
      repeat (pace) @(posedge ref_clk);
      d  = $random(seed);
      be = 4'($random(seed));
      // all lanes disabled gives no strobes, so no write to expect
      if (be == 4'hf) be = 4'he;
      pci_ad_in  <= d;
      pci_cbe_n  <= be;
      pci_irdy_n <= 1'b0;
      done = 0;
      for (int t = 0; t < 50 && !done; t++) begin
        @(posedge ref_clk);
        done = pci_trdy_n === 1'b0;
      end
      if (!done) timed_out();
      exp_q.push_back({~be, d, sa + 16'(4 * k)});
      pci_irdy_n <= 1'b1;
    end
    wr_burst <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  initial begin
    {reset, rd_burst, wr_burst, burst_start, rd_sync, slow, wr_pulse} = 7'h40;
    {pci_irdy_n, pci_cbe_n, start_addr, pci_ad_in, lat_chk} = {5'h1f, 48'h0, 1'b0};
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 4; i++) rd_run(i[0], i[1], 12);
    wr_pulse <= 1'b0;
    wr_run(6, 2);
    wr_pulse <= 1'b1;
    wr_run(6, 1);
    wrap_up();
  end
endmodule

`default_nettype wire
